// ### verilog/srs_reset_seq.sv
`timescale 1ns/1ps
`include "srs_consts.svh"

// Summary of operation
// - The byte 1010 0001 shifted over the serial port is decoded as a software reset.
// - A software reset returns every control byte setting to its default.
// - The software reset is decoded only by a command decoder that is in step.
// - Pattern detection runs apart from the decoder and the software reset; power-on reset and deselect clear it.
// - The 24-bit sequence 0x06D926 puts the device in its power-up default state.
// - The power-on reset puts the device in its default working condition.
// - Setup bits 3..1 written with code 010 go back to default after any reset.

// ****************************************************************
// serial reset sequencer
// ****************************************************************
module srs_reset_seq
    import srs_pkg::*;
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic srst,
    // serial link, sampled synchronously
    input wire logic cs_n,
    input wire logic sclk_rise,
    input wire logic sdi,
    // configuration held by the block
    output logic [`SRS_CFG_W-1:0] cfg_bits,
    output logic [`SRS_CMD_W-1:0] last_cmd,
    // reset status
    output logic dev_reset,
    output srs_src_e reset_src
);
    logic [`SRS_CMD_W-1:0] shift_q;
    logic [`SRS_CMD_W-1:0] shift_d;
    logic [`SRS_BIT_CNT_W-1:0] bit_cnt_q;
    srs_state_e state_q;
    logic [`SRS_CFG_W-1:0] cfg_q;
    logic [`SRS_CMD_W-1:0] cmd_q;
    logic [`SRS_CMD_W-1:0] pending_q;
    logic [`SRS_RST_CNT_W-1:0] rst_cnt_q;
    srs_src_e src_q;
    logic byte_done;
    logic soft_hit;
    logic setup_hit;
    logic pat_hit;
    logic any_rst;
    logic rst_active;
    logic is_cmd;
    logic is_setup;

    // ****************************************************************
    // byte assembly and decode
    // ****************************************************************
    assign shift_d = {shift_q[`SRS_CMD_W-2:0], sdi};
    assign byte_done = !cs_n && sclk_rise && (bit_cnt_q == `SRS_BIT_LAST);
    // a decoder already mid-command treats the byte as data, so a
    // desynchronised decoder cannot be rescued by this command
    assign soft_hit = byte_done && (state_q == SRS_IDLE) &&
                      (shift_d == `SRS_SW_RESET_CMD);
    assign setup_hit = byte_done && (state_q == SRS_DATA) &&
                       (pending_q[`SRS_CODE_MSB:`SRS_CODE_LSB] == `SRS_SETUP_CODE);
    // a set top bit marks a command byte, code 010 among them is setup
    assign is_cmd = shift_d[`SRS_CMD_FLAG];
    assign is_setup = is_cmd && (shift_d[`SRS_CODE_MSB:`SRS_CODE_LSB] == `SRS_SETUP_CODE);
    assign rst_active = (rst_cnt_q != '0);
    assign any_rst = srst || soft_hit || pat_hit || rst_active;

    // independent pattern detector
    srs_pattern_det u_pat (
        .clock(clock),
        .srst(srst),
        .cs_n(cs_n),
        .bit_valid(sclk_rise),
        .bit_in(sdi),
        .match(pat_hit)
    );

    // ****************************************************************
    // command decoder
    // ****************************************************************
    // shift register and bit counter restart on every deselect
    always_ff @(posedge clock) begin
        if (srst || cs_n || pat_hit) begin
            shift_q <= '0;
            bit_cnt_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_q + 1'b1;
        end
    end

    // state: a byte with bit 7 set is a command, setup takes one data byte
    always_ff @(posedge clock) begin
        if (srst || pat_hit || soft_hit) begin
            state_q <= SRS_IDLE;
            pending_q <= '0;
        end else if (byte_done) begin
            case (state_q)
                SRS_IDLE: begin
                    if (is_setup) begin
                        state_q <= SRS_DATA;
                        pending_q <= shift_d;
                    end else if (is_cmd) begin
                        state_q <= SRS_CMD;
                    end
                end
                SRS_CMD: state_q <= SRS_IDLE;
                SRS_DATA: state_q <= SRS_IDLE;
                default: state_q <= SRS_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // configuration and reset pulse
    // ****************************************************************
    // all three sources return the settings to default
    always_ff @(posedge clock) begin
        if (any_rst) begin
            cfg_q <= `SRS_CFG_DEFAULT;
            cmd_q <= '0;
        end else if (setup_hit) begin
            cfg_q <= shift_d[`SRS_CFG_MSB:`SRS_CFG_LSB];
            cmd_q <= pending_q;
        end else if (byte_done && state_q == SRS_IDLE) begin
            cmd_q <= shift_d;
        end
    end

    // stretch each reset to at least 200 ns
    always_ff @(posedge clock) begin
        if (srst) begin
            rst_cnt_q <= `SRS_RST_CNT_W'(`SRS_RESET_CYC);
            src_q <= SRS_SRC_POWER;
        end else if (pat_hit) begin
            rst_cnt_q <= `SRS_RST_CNT_W'(`SRS_RESET_CYC);
            src_q <= SRS_SRC_PATTERN;
        end else if (soft_hit) begin
            rst_cnt_q <= `SRS_RST_CNT_W'(`SRS_RESET_CYC);
            src_q <= SRS_SRC_SOFT;
        end else if (rst_active) begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
        end
    end

    assign cfg_bits = cfg_q;
    assign last_cmd = cmd_q;
    assign dev_reset = rst_active;
    assign reset_src = src_q;
endmodule

// ### verilog/srs_consts.svh
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

// ****************************************************************
// command and pattern values
// ****************************************************************
`define SRS_SW_RESET_CMD 8'hA1
`define SRS_PATTERN 24'h06D926
`define SRS_PATTERN_W 24
`define SRS_CMD_W 8
`define SRS_BIT_CNT_W 3
`define SRS_BIT_LAST 3'h7

// ****************************************************************
// setup configuration bits 3..1 and their reset default
// ****************************************************************
`define SRS_SETUP_CODE 3'h2
`define SRS_CFG_W 3
`define SRS_CFG_DEFAULT 3'h0
`define SRS_CMD_FLAG 7
`define SRS_CODE_MSB 6
`define SRS_CODE_LSB 4
`define SRS_CFG_MSB 3
`define SRS_CFG_LSB 1

// ****************************************************************
// reset pulse length: 200 ns least, 5 ns clock
// ****************************************************************
`define SRS_RESET_NS 200
`define SRS_CLK_NS 5
`define SRS_RESET_CYC ((`SRS_RESET_NS + `SRS_CLK_NS - 1) / `SRS_CLK_NS)
`define SRS_RST_CNT_W 6

`endif

// ### verilog/srs_pkg.sv
package srs_pkg;
    // command decoder state
    typedef enum logic [1:0] {
        SRS_IDLE,
        SRS_CMD,
        SRS_DATA
    } srs_state_e;
    // source of the last reset
    typedef enum logic [1:0] {
        SRS_SRC_POWER,
        SRS_SRC_SOFT,
        SRS_SRC_PATTERN
    } srs_src_e;
endpackage

// ### verilog/srs_pattern_det.sv
`timescale 1ns/1ps
`include "srs_consts.svh"

// ****************************************************************
// pattern reset detector
// ****************************************************************
// shifts every sampled bit while chip select is low and flags a match;
// it has no tie to the command decoder and ignores all internal resets
// except the power-on one, so a lost decoder can never blind it
module srs_pattern_det
    import srs_pkg::*;
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic srst,
    // serial sampling
    input wire logic cs_n,
    input wire logic bit_valid,
    input wire logic bit_in,
    // match
    output logic match
);
    logic [`SRS_PATTERN_W-1:0] hist_q;
    logic [`SRS_PATTERN_W-1:0] hist_d;
    logic hit;

    // history only grows while selected; deselect clears it
    assign hist_d = {hist_q[`SRS_PATTERN_W-2:0], bit_in};
    assign hit = !cs_n && bit_valid && (hist_d == `SRS_PATTERN);
    assign match = hit;

    // shift register, cleared only by its own reset and by deselect
    always_ff @(posedge clock) begin
        if (srst || cs_n) begin
            hist_q <= '0;
        end else if (bit_valid) begin
            hist_q <= hist_d;
        end
    end
endmodule

// ### dv/srs_reset_seq_properties.sv
`timescale 1ns/1ps
`include "srs_consts.svh"
// ********
// reset sequencer checker
// ********
module srs_reset_seq_properties
    import srs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // serial link
    input wire logic cs_n,
    input wire logic sclk_rise,
    input wire logic sdi,
    // watched outputs
    input wire logic [`SRS_CFG_W-1:0] cfg_bits,
    input wire logic [`SRS_CMD_W-1:0] last_cmd,
    input wire logic dev_reset,
    input wire srs_src_e reset_src
);
    // only a bit taken under chip select, or srst, may move source, cfg or last command
    wire taken = sclk_rise && !cs_n;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_start;
        $rose(dev_reset);
    endsequence
    chk_stretch_len: assert property (
        s_start |-> ##39 dev_reset)
        else $error("reset stretch short");
    chk_cfg_default: assert property (
        s_start |-> cfg_bits == `SRS_CFG_DEFAULT)
        else $error("cfg not default");
    chk_rise_cause: assert property (
        s_start |-> $past(taken) || $past(srst))
        else $error("reset without bit");
    chk_soft_bit: assert property (
        (s_start ##0 reset_src == SRS_SRC_SOFT) |-> $past(sdi))
        else $error("soft reset bad bit");
    chk_pat_bit: assert property (
        (s_start ##0 reset_src == SRS_SRC_PATTERN) |-> !$past(sdi))
        else $error("pattern bad bit");
    chk_src_cause: assert property (
        $changed(reset_src) |-> $past(taken) || $past(srst))
        else $error("source moved");
    chk_cfg_cause: assert property (
        $changed(cfg_bits) |-> $past(taken) || $past(srst))
        else $error("cfg moved");
    chk_cmd_cause: assert property (
        $changed(last_cmd) |-> $past(taken) || $past(srst))
        else $error("command moved");
endmodule
bind srs_reset_seq srs_reset_seq_properties i_chk (.clock(clock), .srst(srst), .cs_n(cs_n),
    .sclk_rise(sclk_rise), .sdi(sdi), .cfg_bits(cfg_bits), .last_cmd(last_cmd),
    .dev_reset(dev_reset), .reset_src(reset_src));

// ### dv/srs_host_model.sv
`timescale 1ns/1ps
// ********
// host serial master
// ********
module srs_host_model (
    // clock
    input wire logic clock,
    // serial link
    output logic cs_n,
    output logic sclk_rise,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sclk_rise = 1'b0;
        sdi = 1'b0;
    end
    // select before any bit goes out
    task automatic sel(input logic on);
        @(negedge clock);
        cs_n = !on;
    endtask
    // msb first; data flips between samples so stale values never match
    task automatic xfer(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clock);
            sdi = b[i];
            sclk_rise = 1'b1;
            @(negedge clock);
            sclk_rise = 1'b0;
            sdi = !sdi;
        end
    endtask
endmodule

// ### dv/test_serial_reset_sequence_logic.sv
`timescale 1ns/1ps
`include "srs_consts.svh"
// ********
// reset sequencer bench
// ********
module test_serial_reset_sequence_logic
    import srs_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cs_n;
    logic sclk_rise;
    logic sdi;
    logic [`SRS_CFG_W-1:0] cfg_bits;
    logic [`SRS_CMD_W-1:0] last_cmd;
    logic dev_reset;
    srs_src_e reset_src;
    logic [23:0] p = `SRS_PATTERN;
    int err_total = 0;
    int num_checks = 0;
    always #2.5 clock = ~clock;
    srs_host_model i_host (.clock(clock), .cs_n(cs_n), .sclk_rise(sclk_rise), .sdi(sdi));
    srs_reset_seq i_dut (.clock(clock), .srst(srst), .cs_n(cs_n), .sclk_rise(sclk_rise),
        .sdi(sdi), .cfg_bits(cfg_bits), .last_cmd(last_cmd), .dev_reset(dev_reset),
        .reset_src(reset_src));
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one line compares cfg, source, reset flag and last command byte
    task automatic st(input logic [2:0] c, input logic [1:0] s, input logic r,
        input logic [7:0] m);
        @(negedge clock);
        num_checks++;
        if ({cfg_bits, reset_src, dev_reset, last_cmd} !== {c, s, r, m}) begin
            err_total++;
            $display("BAD %0t %h %h", $time, {cfg_bits, reset_src, dev_reset, last_cmd},
                {c, s, r, m});
        end
    endtask
    // bounded wait for the stretch to end
    task automatic wait_idle();
        int n;
        for (n = 0; n < 100 && dev_reset !== 1'b0; n++) @(negedge clock);
        if (n == 100) begin
            err_total++;
            stop_test();
        end else begin
            // called right after st saw the second stretch cycle
            num_checks++;
            if (n + 1 != `SRS_RESET_CYC) begin
                err_total++;
                $display("BAD %0t %h %h", $time, n + 1, `SRS_RESET_CYC);
            end
        end
    endtask
    // power-on reset, used at start and again at the end
    task automatic t_por();
        srst = 1'b1;
        repeat (5) @(negedge clock);
        srst = 1'b0;
        st(`SRS_CFG_DEFAULT, SRS_SRC_POWER, 1'b1, 8'h00);
        wait_idle();
    endtask
    // setup load, then a soft reset command
    task automatic t_soft();
        i_host.sel(1'b1);
        i_host.xfer(8'hA0);
        i_host.xfer(8'h0E);
        st(3'h7, SRS_SRC_POWER, 1'b0, 8'hA0);
        i_host.sel(1'b0);
        i_host.sel(1'b1);
        i_host.xfer(`SRS_SW_RESET_CMD);
        st(`SRS_CFG_DEFAULT, SRS_SRC_SOFT, 1'b1, 8'h00);
        wait_idle();
        i_host.sel(1'b0);
    endtask
    // decoder out of step: soft command lost as data, pattern still resets
    task automatic t_pattern();
        i_host.sel(1'b1);
        i_host.xfer(8'hA0);
        i_host.xfer(8'h0E);
        i_host.xfer(8'h80);
        i_host.xfer(`SRS_SW_RESET_CMD);
        st(3'h7, SRS_SRC_SOFT, 1'b0, 8'h80);
        i_host.xfer(p[23:16]);
        i_host.xfer(p[15:8]);
        i_host.xfer(p[7:0]);
        st(`SRS_CFG_DEFAULT, SRS_SRC_PATTERN, 1'b1, 8'h00);
        wait_idle();
        i_host.sel(1'b0);
    endtask
    // chip select broken mid-pattern, then bits while deselected
    task automatic t_refused();
        i_host.sel(1'b1);
        i_host.xfer(p[23:16]);
        i_host.xfer(p[15:8]);
        i_host.sel(1'b0);
        i_host.sel(1'b1);
        i_host.xfer(p[7:0]);
        i_host.sel(1'b0);
        i_host.xfer(`SRS_SW_RESET_CMD);
        st(`SRS_CFG_DEFAULT, SRS_SRC_PATTERN, 1'b0, 8'hD9);
    endtask
    initial begin
        t_por();
        t_soft();
        t_pattern();
        t_refused();
        t_por();
        stop_test();
    end
endmodule
